// ### hdl/pin_remap.v
// pin remap, usb pin, input buffer disable and port interrupt configuration
// What this block does
// (R1) bit 6 picks serial2 alternate pair on PA6/PA7
// (R2) bit 5 moves serial1 to PB12/PB13 from PA8/PA9
// (R3) bit 4 moves serial0 to PA15/PA14 from PB4/PB7
// (R4) bit 2 moves timer2 pin to PB11 from PA11
// (R5) bit 1 moves timer1 pin to PB10 from PA10
// (R6) bit 0 moves timer0 pin to PB23 from PA9
// (R7) remap bits 7,3 read zero; selects reset zero
// (R8) analog bit 7 claims PB10/PB11 for usb
// (R9) analog bit 6 forces usb D+ pullup on
// (R10) software should disable inputs on analog pins
// (R11) bits 31:26 disable inputs PB10..PB15
// (R12) bits 25:24 disable inputs PB22,PB23
// (R13) bits 23:22 disable inputs PB6,PB7
// (R14) bit 20 disables PB4; 21,19:17 reserved
// (R15) bit 16 disables PB0 input
// (R16) bits 15:4 disable PA4..PA15; 3:0 reserved
// (R17) one turns input buffer off; reset zero
// (R18) port A interrupt enables, reset clear
// (R19) port B interrupt enables, reset clear
// (R20) port A mode: one edge, zero level
// (R21) port B mode: one edge, zero level
// (R22) output latch bit picks interrupt polarity
// (R23) flag set by hardware, write one clears
// (R24) pins synchronised before edge or level detect
// (R25) level mode keeps flag set while level holds
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pin_remap_defines.vh"
module pin_remap (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    // axi4-lite write address
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [11:0] i_awaddr,
    // axi4-lite write data
    input  wire        i_wvalid,
    output reg         o_wready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    // axi4-lite write response
    output reg         o_bvalid,
    input  wire        i_bready,
    output reg  [1:0]  o_bresp,
    // axi4-lite read address
    input  wire        i_arvalid,
    output reg         o_arready,
    input  wire [11:0] i_araddr,
    // axi4-lite read data
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    // pins and usb controller
    input  wire [15:0] i_porta_pins,
    input  wire [15:0] i_portb_pins,
    input  wire        i_usb_ctrl_pullup_enable,
    // pin selects
    output reg         o_serial2_pin_select,
    output reg         o_serial1_pin_select,
    output reg         o_serial0_pin_select,
    output reg         o_timer2_pin_select,
    output reg         o_timer1_pin_select,
    output reg         o_timer0_pin_select,
    // usb pins
    output reg         o_usb_pin_claim,
    output reg         o_usb_dplus_pullup,
    // input buffer disables
    output reg  [15:0] o_porta_input_buffer_off,
    output reg  [23:0] o_portb_input_buffer_off,
    // interrupt flags
    output reg  [15:0] o_porta_irq_flags,
    output reg  [15:0] o_portb_irq_flags
);

    reg  [7:0]  remap_q;
    reg  [15:0] analog_q;
    reg  [31:0] din_q;
    reg  [15:0] pa_en_q;
    reg  [15:0] pb_en_q;
    reg  [15:0] pa_mode_q;
    reg  [15:0] pb_mode_q;
    reg  [15:0] pa_out_q;
    reg  [15:0] pb_out_q;
    reg  [11:0] awaddr_q;
    reg         aw_held_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         w_held_q;
    reg  [15:0] pa_clear;
    reg  [15:0] pb_clear;
    reg         wr_hit;
    reg  [31:0] rd_val;
    reg         rd_hit;
    wire [15:0] pa_flags;
    wire [15:0] pb_flags;
    wire        wr_go;
    wire [31:0] wmask;
    reg  [31:0] wr_old;
    reg  [31:0] wr_keep;
    wire [31:0] wr_val;

    // byte enables expand to a bit mask
    function [31:0] strb_mask;
        input [3:0] s;
        begin
            strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    // masked merge of write data into an old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] m;
        begin
            merge = (old & ~m) | (data & m);
        end
    endfunction

    assign wr_go = aw_held_q & w_held_q & ~o_bvalid;
    assign wmask = strb_mask(wstrb_q);
    assign wr_val = merge(wr_old, wdata_q, wmask & wr_keep);

    // present value and writable bits of the addressed register; the
    // keep mask holds reserved bits at zero whatever software writes
    always @* begin
        wr_old  = 32'h00000000;
        wr_keep = 32'h00000000;
        case (awaddr_q)
            `OFS_REMAP: begin
                wr_old  = {24'h000000, remap_q};
                wr_keep = {24'h000000, `REMAP_MASK};              // [R7]
            end
            `OFS_ANALOG_USB: begin
                wr_old  = {16'h0000, analog_q};
                wr_keep = {16'h0000, `ANALOG_MASK};          // [R8] [R9]
            end
            `OFS_DIN_DISABLE: begin
                wr_old  = din_q;
                wr_keep = `DIN_MASK;                        // [R14] [R16]
            end
            `OFS_PA_IRQ_EN: begin
                wr_old  = {16'h0000, pa_en_q};
                wr_keep = 32'h0000FFFF;
            end
            `OFS_PB_IRQ_EN: begin
                wr_old  = {16'h0000, pb_en_q};
                wr_keep = 32'h0000FFFF;
            end
            `OFS_PA_IRQ_MODE: begin
                wr_old  = {16'h0000, pa_mode_q};
                wr_keep = 32'h0000FFFF;
            end
            `OFS_PB_IRQ_MODE: begin
                wr_old  = {16'h0000, pb_mode_q};
                wr_keep = 32'h0000FFFF;
            end
            `OFS_PA_OUT_LATCH: begin
                wr_old  = {16'h0000, pa_out_q};
                wr_keep = 32'h0000FFFF;
            end
            `OFS_PB_OUT_LATCH: begin
                wr_old  = {16'h0000, pb_out_q};
                wr_keep = 32'h0000FFFF;
            end
            default: wr_keep = 32'h00000000;
        endcase
    end

    // write-one-to-clear strobes and address decode
    always @* begin
        pa_clear = 16'h0000;
        pb_clear = 16'h0000;
        wr_hit   = 1'b1;
        case (awaddr_q)
            `OFS_REMAP, `OFS_ANALOG_USB, `OFS_DIN_DISABLE, `OFS_PA_IRQ_EN,
            `OFS_PB_IRQ_EN, `OFS_PA_IRQ_MODE, `OFS_PB_IRQ_MODE,
            `OFS_PA_OUT_LATCH, `OFS_PB_OUT_LATCH: wr_hit = 1'b1;
            `OFS_PA_IRQ_FLAGS: begin
                if (wr_go) begin
                    pa_clear = wdata_q[15:0] & wmask[15:0];        // [R23]
                end
            end
            `OFS_PB_IRQ_FLAGS: begin
                if (wr_go) begin
                    pb_clear = wdata_q[15:0] & wmask[15:0];        // [R23]
                end
            end
            default: wr_hit = 1'b0;
        endcase
    end

    // read decode; reserved bits read zero because the write keep mask never sets them
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (i_araddr)
            `OFS_REMAP:         rd_val = {24'h000000, remap_q};     // [R7]
            `OFS_ANALOG_USB:    rd_val = {16'h0000, analog_q};
            `OFS_DIN_DISABLE:   rd_val = din_q;                     // [R14] [R16]
            `OFS_PA_IRQ_EN:     rd_val = {16'h0000, pa_en_q};
            `OFS_PB_IRQ_EN:     rd_val = {16'h0000, pb_en_q};
            `OFS_PA_IRQ_MODE:   rd_val = {16'h0000, pa_mode_q};
            `OFS_PB_IRQ_MODE:   rd_val = {16'h0000, pb_mode_q};
            `OFS_PA_IRQ_FLAGS:  rd_val = {16'h0000, pa_flags};
            `OFS_PB_IRQ_FLAGS:  rd_val = {16'h0000, pb_flags};
            `OFS_PA_OUT_LATCH:  rd_val = {16'h0000, pa_out_q};
            `OFS_PB_OUT_LATCH:  rd_val = {16'h0000, pb_out_q};
            default:            rd_hit = 1'b0;
        endcase
    end

    // write channel: address and data taken in either order
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            remap_q   <= 8'h00;                                     // [R7]
            analog_q  <= `RESET_16;
            din_q     <= `RESET_32;                                 // [R17]
            pa_en_q   <= `RESET_16;                                 // [R18]
            pb_en_q   <= `RESET_16;                                 // [R19]
            pa_mode_q <= `RESET_16;                                 // [R20]
            pb_mode_q <= `RESET_16;                                 // [R21]
            pa_out_q  <= `RESET_16;
            pb_out_q  <= `RESET_16;
        end else begin
            o_awready <= ~aw_held_q & ~o_awready & i_awvalid;
            o_wready  <= ~w_held_q & ~o_wready & i_wvalid;
            if (o_awready & i_awvalid) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end
            if (o_wready & i_wvalid) begin
                w_held_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                case (awaddr_q)
                    `OFS_REMAP:        remap_q   <= wr_val[7:0];  // [R7]
                    `OFS_ANALOG_USB:   analog_q  <= wr_val[15:0]; // [R8] [R9]
                    `OFS_DIN_DISABLE:  din_q     <= wr_val;  // [R14] [R16]
                    `OFS_PA_IRQ_EN:    pa_en_q   <= wr_val[15:0]; // [R18]
                    `OFS_PB_IRQ_EN:    pb_en_q   <= wr_val[15:0]; // [R19]
                    `OFS_PA_IRQ_MODE:  pa_mode_q <= wr_val[15:0]; // [R20]
                    `OFS_PB_IRQ_MODE:  pb_mode_q <= wr_val[15:0]; // [R21]
                    `OFS_PA_OUT_LATCH: pa_out_q  <= wr_val[15:0]; // [R22]
                    `OFS_PB_OUT_LATCH: pb_out_q  <= wr_val[15:0]; // [R22]
                    default: remap_q <= remap_q;
                endcase
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one-cycle accept, data the cycle after
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `RESP_OKAY;
        end else begin
            o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
            if (o_arready & i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_val;
                o_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // pin and usb outputs, registered one cycle after the config
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_serial2_pin_select     <= 1'b0;
            o_serial1_pin_select     <= 1'b0;
            o_serial0_pin_select     <= 1'b0;
            o_timer2_pin_select      <= 1'b0;
            o_timer1_pin_select      <= 1'b0;
            o_timer0_pin_select      <= 1'b0;
            o_usb_pin_claim          <= 1'b0;
            o_usb_dplus_pullup       <= 1'b0;
            o_porta_input_buffer_off <= 16'h0000;
            o_portb_input_buffer_off <= 24'h000000;
        end else begin
            o_serial2_pin_select <= remap_q[`BIT_SERIAL2];          // [R1]
            o_serial1_pin_select <= remap_q[`BIT_SERIAL1];          // [R2]
            o_serial0_pin_select <= remap_q[`BIT_SERIAL0];          // [R3]
            o_timer2_pin_select  <= remap_q[`BIT_TIMER2];           // [R4]
            o_timer1_pin_select  <= remap_q[`BIT_TIMER1];           // [R5]
            o_timer0_pin_select  <= remap_q[`BIT_TIMER0];           // [R6]
            o_usb_pin_claim      <= analog_q[`BIT_USB_CLAIM];       // [R8]
            // the force keeps the pull-up when the controller cannot
            o_usb_dplus_pullup   <= analog_q[`BIT_USB_PU] |
                                    i_usb_ctrl_pullup_enable;       // [R9]
            o_porta_input_buffer_off <= {din_q[15:4], 4'h0};        // [R16] [R17]
            o_portb_input_buffer_off <= {din_q[25:24], 6'h00,
                din_q[31:26], 2'h0, din_q[23:22], 1'b0, din_q[20],
                3'h0, din_q[16]};         // [R11] [R12] [R13] [R14] [R15]
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_porta_irq_flags <= 16'h0000;
            o_portb_irq_flags <= 16'h0000;
        end else begin
            o_porta_irq_flags <= pa_flags;
            o_portb_irq_flags <= pb_flags;
        end
    end

    pin_irq_detect u_porta_irq (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_pins      (i_porta_pins),
        .i_enable    (pa_en_q),
        .i_edge_mode (pa_mode_q),
        .i_polarity  (pa_out_q),
        .i_clear     (pa_clear),
        .o_flags     (pa_flags)
    );

    pin_irq_detect u_portb_irq (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_pins      (i_portb_pins),
        .i_enable    (pb_en_q),
        .i_edge_mode (pb_mode_q),
        .i_polarity  (pb_out_q),
        .i_clear     (pb_clear),
        .o_flags     (pb_flags)
    );

endmodule

// ### hdl/pin_remap_defines.vh
// register offsets, field positions and reset values for the pin remap block
`ifndef PIN_REMAP_DEFINES_VH
`define PIN_REMAP_DEFINES_VH

`define OFS_REMAP        12'h000
`define OFS_ANALOG_USB   12'h004
`define OFS_DIN_DISABLE  12'h008
`define OFS_PA_IRQ_EN    12'h00C
`define OFS_PB_IRQ_EN    12'h010
`define OFS_PA_IRQ_MODE  12'h014
`define OFS_PB_IRQ_MODE  12'h018
`define OFS_PA_IRQ_FLAGS 12'h01C
`define OFS_PB_IRQ_FLAGS 12'h020
`define OFS_PA_OUT_LATCH 12'h024
`define OFS_PB_OUT_LATCH 12'h028

`define BIT_TIMER0   0
`define BIT_TIMER1   1
`define BIT_TIMER2   2
`define BIT_SERIAL0  4
`define BIT_SERIAL1  5
`define BIT_SERIAL2  6
`define BIT_USB_CLAIM 7
`define BIT_USB_PU   6

`define REMAP_MASK   8'h77
`define ANALOG_MASK  16'h00C0
`define DIN_MASK     32'hFFD1FFF0
`define RESET_16     16'h0000
`define RESET_32     32'h00000000

`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// ### hdl/pin_irq_detect.v
// per-pin synchroniser and level/edge interrupt flag logic for one port
`timescale 1ns/1ps
module pin_irq_detect (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    // pin and configuration
    input  wire [15:0] i_pins,
    input  wire [15:0] i_enable,
    input  wire [15:0] i_edge_mode,
    input  wire [15:0] i_polarity,
    input  wire [15:0] i_clear,
    // flags
    output reg  [15:0] o_flags
);

    reg  [15:0] sync1_q;
    reg  [15:0] sync2_q;
    reg  [15:0] prev_q;
    wire [15:0] active;
    wire [15:0] edge_hit;
    wire [15:0] hit;

    // polarity 1 means high or rising, 0 means low or falling
    assign active   = ~(sync2_q ^ i_polarity);                  // [R22]
    assign edge_hit = (sync2_q ^ prev_q) & active;              // [R24]
    // level mode re-sets every cycle while the level holds
    assign hit = i_enable & ((i_edge_mode & edge_hit) |
                 (~i_edge_mode & active));          // [R20] [R21] [R25]

    always @(posedge i_clock) begin
        if (i_rst) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
            prev_q  <= 16'h0000;
            o_flags <= 16'h0000;
        end else begin
            sync1_q <= i_pins;                                  // [R24]
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            // a new event wins over a clear in the same cycle
            o_flags <= (o_flags & ~i_clear) | hit;              // [R23]
        end
    end

endmodule

// ### test/pin_remap_asserts.sv
// concurrent checks on the pin remap block ports
`timescale 1ns/1ps
module pin_remap_asserts (
    // clock and reset
    input wire        i_clock,
    input wire        i_rst,
    // bus handshakes
    input wire        i_awvalid,
    input wire        o_awready,
    input wire        i_wvalid,
    input wire        o_wready,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire [31:0] o_rdata,
    // pin side
    input wire        i_usb_ctrl_pullup_enable,
    input wire        o_usb_dplus_pullup,
    input wire        o_timer0_pin_select,
    input wire [15:0] o_porta_input_buffer_off,
    input wire [23:0] o_portb_input_buffer_off,
    input wire [15:0] o_porta_irq_flags
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence write_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence read_taken;
        i_arvalid && o_arready;
    endsequence
    a_write_answer: assert property (write_taken |-> ##[1:3] o_bvalid)
        else $error("write response late");
    a_read_answer: assert property (read_taken |-> ##[1:3] o_rvalid)
        else $error("read data late");
    a_ready_pulse: assert property (o_awready |=> !o_awready)
        else $error("awready longer than one cycle");
    a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    a_pullup_force: assert property (
        !i_rst && i_usb_ctrl_pullup_enable |=> o_usb_dplus_pullup)
        else $error("usb pullup not following controller");
    // the timer0 select only moves after a bus write completes
    a_select_on_write: assert property (
        $changed(o_timer0_pin_select) && !$past(i_rst) |-> $past(o_bvalid))
        else $error("timer0 select moved without write");
    a_reserved_zero: assert property (
        o_porta_input_buffer_off[3:0] == 4'h0
        && (o_portb_input_buffer_off & 24'h3F032E) == 24'h000000)
        else $error("reserved input disable bit set");
    a_reset_clears: assert property (
        $fell(i_rst) |-> !o_timer0_pin_select
        && o_porta_input_buffer_off == 16'h0000
        && o_porta_irq_flags == 16'h0000)
        else $error("outputs not cleared by reset");
endmodule
bind pin_remap pin_remap_asserts pin_remap_asserts_inst (
    .i_clock, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
    .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
    .o_rdata, .i_usb_ctrl_pullup_enable, .o_usb_dplus_pullup,
    .o_timer0_pin_select, .o_porta_input_buffer_off,
    .o_portb_input_buffer_off, .o_porta_irq_flags);

// ### test/testbench.sv
// self-checking bench for the pin remap block
`timescale 1ns/1ps
`include "pin_remap_defines.vh"
module testbench;
    reg         i_clock, i_rst, i_awvalid, i_wvalid, i_bready;
    reg         i_arvalid, i_rready, i_usb_ctrl_pullup_enable;
    reg  [11:0] i_awaddr, i_araddr;
    reg  [31:0] i_wdata, rdat;
    reg  [3:0]  i_wstrb;
    reg  [1:0]  resp;
    reg  [15:0] i_porta_pins, i_portb_pins;
    wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire [1:0]  o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire        o_serial2_pin_select, o_serial1_pin_select;
    wire        o_serial0_pin_select, o_timer2_pin_select;
    wire        o_timer1_pin_select, o_timer0_pin_select;
    wire        o_usb_pin_claim, o_usb_dplus_pullup;
    wire [15:0] o_porta_input_buffer_off, o_porta_irq_flags;
    wire [15:0] o_portb_irq_flags;
    wire [23:0] o_portb_input_buffer_off;
    wire [5:0]  sel;
    integer     err_total, samples_checked, cycles, k;
    reg  [75:0] rows [0:6];
    assign sel = {o_serial2_pin_select, o_serial1_pin_select,
        o_serial0_pin_select, o_timer2_pin_select, o_timer1_pin_select,
        o_timer0_pin_select};
    pin_remap pin_remap_inst (.i_clock, .i_rst, .i_awvalid, .o_awready,
        .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid,
        .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
        .i_rready, .o_rdata, .o_rresp, .i_porta_pins, .i_portb_pins,
        .i_usb_ctrl_pullup_enable, .o_serial2_pin_select,
        .o_serial1_pin_select, .o_serial0_pin_select, .o_timer2_pin_select,
        .o_timer1_pin_select, .o_timer0_pin_select, .o_usb_pin_claim,
        .o_usb_dplus_pullup, .o_porta_input_buffer_off,
        .o_portb_input_buffer_off, .o_porta_irq_flags, .o_portb_irq_flags);
    task check(input string what, input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bready is raised with the request so the answer is taken at once
    task wr(input [11:0] a, input [31:0] d);
        @(posedge i_clock);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= d;
        i_bready <= 1'b1;
        while (!o_bvalid) begin
            @(posedge i_clock);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end
        resp = o_bresp;
        i_bready <= 1'b0;
    endtask
    task rd(input [11:0] a);
        @(posedge i_clock);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        while (!o_rvalid) begin
            @(posedge i_clock);
            if (o_arready) i_arvalid <= 1'b0;
        end
        rdat = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask
    // sync pin path plus one output stage; note gives 3-4 cycles
    task settle;
        repeat (4) @(posedge i_clock);
    endtask
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_awaddr, i_araddr, i_wdata, rdat} = 88'h0;
        i_wstrb = 4'hF;
        i_usb_ctrl_pullup_enable = 1'b0;
        i_porta_pins = 16'h0000;
        i_portb_pins = 16'h0000;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        rows[0] = {`OFS_REMAP, 32'h000000FF, 32'h00000077};
        rows[1] = {`OFS_ANALOG_USB, 32'h0000FFFF, 32'h000000C0};
        rows[2] = {`OFS_DIN_DISABLE, 32'hFFFFFFFF, 32'hFFD1FFF0};
        rows[3] = {`OFS_PA_IRQ_EN, 32'hFFFFA5A5, 32'h0000A5A5};
        rows[4] = {`OFS_PB_IRQ_EN, 32'h00005A5A, 32'h00005A5A};
        rows[5] = {`OFS_PA_IRQ_MODE, 32'h0000FFFF, 32'h0000FFFF};
        rows[6] = {`OFS_PB_IRQ_MODE, 32'h00001234, 32'h00001234};
        i_rst = 1'b1;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        for (k = 0; k < 7; k = k + 1) begin
            rd(rows[k][75:64]);
            check("reset value", rdat, 32'h0);
            wr(rows[k][75:64], rows[k][63:32]);
            rd(rows[k][75:64]);
            check("readback", rdat, rows[k][31:0]);
        end
        repeat (2) @(posedge i_clock);
        check("selects", sel, 32'h3F);
        check("usb", {o_usb_pin_claim, o_usb_dplus_pullup}, 2'h3);
        check("pa off", o_porta_input_buffer_off, 32'hFFF0);
        check("pb off", o_portb_input_buffer_off, 32'hC0FCD1);
        i_wstrb <= 4'h1;
        wr(`OFS_PB_IRQ_MODE, 32'h0000FFFF);
        i_wstrb <= 4'hF;
        rd(`OFS_PB_IRQ_MODE);
        check("byte strobe", rdat, 32'h12FF);
        $display("test register rows done");
        wr(`OFS_REMAP, 32'h00000015);
        wr(`OFS_ANALOG_USB, 32'h00000000);
        @(posedge i_clock);
        i_usb_ctrl_pullup_enable <= 1'b1;
        repeat (2) @(posedge i_clock);
        check("selects", sel, 32'h0D);
        check("usb", {o_usb_pin_claim, o_usb_dplus_pullup}, 2'h1);
        i_usb_ctrl_pullup_enable <= 1'b0;
        repeat (2) @(posedge i_clock);
        check("pullup", o_usb_dplus_pullup, 1'b0);
        wr(12'h100, 32'hFFFFFFFF);
        check("bresp", resp, `RESP_SLVERR);
        rd(12'h100);
        check("rresp", resp, `RESP_SLVERR);
        check("rdata", rdat, 32'h0);
        $display("test remap usb and unmapped done");
        wr(`OFS_PA_IRQ_EN, 32'h0);
        wr(`OFS_PB_IRQ_EN, 32'h0);
        wr(`OFS_PA_IRQ_MODE, 32'h0);
        wr(`OFS_PB_IRQ_MODE, 32'h0);
        wr(`OFS_PA_IRQ_FLAGS, 32'hFFFF);
        wr(`OFS_PB_IRQ_FLAGS, 32'hFFFF);
        rd(`OFS_PA_IRQ_FLAGS);
        check("flags cleared", rdat, 32'h0);
        wr(`OFS_PA_OUT_LATCH, 32'h5);
        wr(`OFS_PA_IRQ_EN, 32'h1);
        i_porta_pins <= 16'h0005;
        settle;
        rd(`OFS_PA_IRQ_FLAGS);
        check("level flag", rdat, 32'h1);
        check("pa flag out", o_porta_irq_flags, 32'h1);
        wr(`OFS_PA_IRQ_FLAGS, 32'h1);
        rd(`OFS_PA_IRQ_FLAGS);
        check("level persists", rdat, 32'h1);
        i_porta_pins <= 16'h0000;
        settle;
        wr(`OFS_PA_IRQ_FLAGS, 32'h1);
        rd(`OFS_PA_IRQ_FLAGS);
        check("flag clear", rdat, 32'h0);
        wr(`OFS_PA_IRQ_MODE, 32'h1);
        i_porta_pins <= 16'h0001;
        settle;
        rd(`OFS_PA_IRQ_FLAGS);
        check("edge flag", rdat, 32'h1);
        wr(`OFS_PA_IRQ_FLAGS, 32'h1);
        rd(`OFS_PA_IRQ_FLAGS);
        check("edge once", rdat, 32'h0);
        check("pa flag out clear", o_porta_irq_flags, 32'h0);
        wr(`OFS_PB_IRQ_EN, 32'h8);
        settle;
        rd(`OFS_PB_IRQ_FLAGS);
        check("pb low level", rdat, 32'h8);
        check("pb flag out", o_portb_irq_flags, 32'h8);
        $display("test interrupts done");
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(`OFS_PB_IRQ_EN);
        check("reset enable", rdat, 32'h0);
        check("reset selects", sel, 32'h0);
        check("reset pb flags", o_portb_irq_flags, 32'h0);
        $display("test second reset done");
        summarize;
    end
endmodule
